/* lcd_cmd_consts.svh */
// Opcode patterns, field positions and reset values of the LCD command decoder
`ifndef LCD_CMD_CONSTS_SVH
`define LCD_CMD_CONSTS_SVH

// Command byte patterns (? marks don't-care bits)
`define OP_DISP_ONOFF   8'b1010_111?
`define OP_START_LINE   8'b01??_????
`define OP_PAGE_SET     8'b1011_????
`define OP_COL_HIGH     8'b0001_????
`define OP_COL_LOW      8'b0000_????
`define OP_SEG_DIR      8'b1010_000?
`define OP_REVERSE      8'b1010_011?
`define OP_ALL_ON       8'b1010_010?
`define OP_BIAS         8'b1010_001?
`define OP_RMW_ENTER    8'b1110_0000
`define OP_RMW_END      8'b1110_1110
`define OP_SOFT_RESET   8'b1110_0010
`define OP_COM_SCAN     8'b1100_????
`define OP_POWER_CTRL   8'b0010_1???
`define OP_GAIN_RATIO   8'b0010_0???
`define OP_VOLUME_MODE  8'b1000_0001
`define OP_INDICATOR    8'b1010_110?
`define OP_NOP          8'b1110_0011
`define OP_TEST         8'b1111_????

// Field positions inside a command byte
`define FLD_SETTING     0
`define FLD_COM_SCAN    3
`define FLD_BOOSTER     2
`define FLD_REGULATOR   1
`define FLD_FOLLOWER    0
`define FLD_NIBBLE_MSB  3
`define FLD_LINE_MSB    5
`define FLD_RATIO_MSB   2
`define FLD_VOLUME_MSB  5
`define FLD_IND_MSB     1

// Column address limit and reset values
`define COL_MAX         8'h83
`define COL_RST         8'h00
`define PAGE_RST        4'h0
`define LINE_RST        6'h00
`define RATIO_RST       3'h0
`define VOLUME_RST      6'h20
`define IND_RST         2'h0

`endif

/* lcd_cmd_pkg.sv */
// Types shared by the LCD command decoder modules
package lcd_cmd_pkg;

  // Byte expected next from the host
  typedef enum logic [1:0] {
    ST_COMMAND   = 2'h0,
    ST_VOLUME    = 2'h1,
    ST_INDICATOR = 2'h3
  } decode_state_e;

  typedef logic [7:0] col_addr_t;

endpackage : lcd_cmd_pkg

/* col_ctrl_if.sv */
// Control bundle between the command decoder and the column address unit
`timescale 1ns/1ps
interface col_ctrl_if;
  logic                  setHigh;
  logic                  setLow;
  logic [3:0]            nibble;
  logic                  advance;
  logic                  save;
  logic                  restore;
  logic                  softReset;
  lcd_cmd_pkg::col_addr_t colAddr;

  modport ctrl (output setHigh, output setLow, output nibble, output advance,
                output save, output restore, output softReset, input colAddr);
  modport unit (input setHigh, input setLow, input nibble, input advance,
                input save, input restore, input softReset, output colAddr);
endinterface : col_ctrl_if

/* col_addr_unit.sv */
// Column address counter with saturation and read/modify/write save slot
`timescale 1ns/1ps
`include "lcd_cmd_consts.svh"
module col_addr_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control from the decoder
  col_ctrl_if.unit cif
);

  lcd_cmd_pkg::col_addr_t col;
  lcd_cmd_pkg::col_addr_t saved;
  lcd_cmd_pkg::col_addr_t next_col;
  lcd_cmd_pkg::col_addr_t next_saved;

  always_comb begin
    next_col   = col;
    next_saved = saved;
    if (cif.save) begin
      next_saved = col;
    end
    if (cif.softReset) begin
      next_col = `COL_RST;
    end else if (cif.restore) begin
      next_col = saved;                                  // RULE_09
    end else if (cif.setHigh) begin
      next_col = {cif.nibble, col[3:0]};
    end else if (cif.setLow) begin
      next_col = {col[7:4], cif.nibble};
    end else if (cif.advance && col < `COL_MAX) begin
      // Stops at the last column; page never changes here
      next_col = col + 8'h01;                            // RULE_02
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      col   <= `COL_RST;
      saved <= `COL_RST;
    end else begin
      col   <= next_col;
      saved <= next_saved;
    end
  end

  assign cif.colAddr = col;

endmodule : col_addr_unit

/* lcd_command_decoder.sv */
// Command byte decoder holding display, power and addressing settings
//
// Overview of operation
// RULE_01: Data-select high write stores a byte at current RAM address, column advances.
// RULE_02: Column auto-increment stops at 83h, never wraps or touches the page.
// RULE_03: Each write with data-select low is one command; don't-care bits ignored.
// RULE_04: A6/A7 choose normal or inverted pixel polarity from D0; RAM untouched.
// RULE_05: A4/A5 clear or set all-pixels-on from D0; overrides data and polarity.
// RULE_06: All-pixels-on while display is off enters power save.
// RULE_07: A2/A3 store bias select from D0; zero picks the higher bias.
// RULE_08: E0 saves column and enters read/modify/write; reads then keep column.
// RULE_09: Read/modify/write lasts until EE, which restores the saved column.
// RULE_10: Host must not set column address during read/modify/write.
// RULE_11: E2 restores line, column, page, scan, ratio, volume, indicator; ends modes.
// RULE_12: Soft reset leaves RAM unchanged and acts after the byte is received.
// RULE_13: Host must use the hardware reset pin at power-up, not soft reset.
// RULE_14: C0-CF take common scan direction from D3, other low bits ignored.
// RULE_15: 28-2F set booster, regulator and follower enables from D2, D1, D0.
// RULE_16: 20-27 store the low three bits as regulator gain ratio.
// RULE_17: After 81 the next command byte is taken only as the volume value.
// RULE_18: That byte loads D5-D0 as six-bit volume, then volume mode ends.
// RULE_19: Host not using volume control should load binary 100000.
`timescale 1ns/1ps
`include "lcd_cmd_consts.svh"
module lcd_command_decoder (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Host port, one-cycle strobes from the host interface logic
  input  wire logic       hostWrStrobe,
  input  wire logic       hostRdStrobe,
  input  wire logic       cmdDataSelect,
  input  wire logic [7:0] hostData,
  // Display RAM write port
  output logic            ramWrEn,
  output logic [7:0]      ramWrData,
  output logic [3:0]      ramPage,
  output logic [7:0]      ramColumn,
  // Addressing state
  output logic [3:0]      pageAddr,
  output logic [7:0]      columnAddr,
  output logic [5:0]      startLine,
  // Display settings
  output logic            displayOn,
  output logic            segReverse,
  output logic            reversePolarity,
  output logic            allPointsOn,
  output logic            powerSave,
  output logic            biasSelect,
  output logic            comScanReverse,
  // Mode flags
  output logic            rmwActive,
  output logic            testMode,
  output logic            volumeMode,
  // Power circuit settings
  output logic            boosterEn,
  output logic            regulatorEn,
  output logic            followerEn,
  output logic [2:0]      regulatorGainRatio,
  output logic [5:0]      volumeLevel,
  // Static indicator
  output logic            indicatorOn,
  output logic [1:0]      indicatorMode
);

  col_ctrl_if colBus ();

  col_addr_unit colUnit (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cif     (colBus)
  );

  lcd_cmd_pkg::decode_state_e state;
  lcd_cmd_pkg::decode_state_e next_state;

  logic       next_displayOn;
  logic       next_segReverse;
  logic       next_reversePolarity;
  logic       next_allPointsOn;
  logic       next_powerSave;
  logic       next_biasSelect;
  logic       next_comScanReverse;
  logic       next_rmwActive;
  logic       next_testMode;
  logic       next_boosterEn;
  logic       next_regulatorEn;
  logic       next_followerEn;
  logic [2:0] next_regulatorGainRatio;
  logic [5:0] next_volumeLevel;
  logic       next_indicatorOn;
  logic [1:0] next_indicatorMode;
  logic [3:0] next_pageAddr;
  logic [5:0] next_startLine;
  logic       next_ramWrEn;
  logic [7:0] next_ramWrData;
  logic [3:0] next_ramPage;
  logic [7:0] next_ramColumn;

  logic cmdWrite;
  logic dataWrite;
  logic dataRead;

  assign cmdWrite  = hostWrStrobe & ~cmdDataSelect;                                 // RULE_03
  assign dataWrite = hostWrStrobe & cmdDataSelect;
  assign dataRead  = hostRdStrobe & cmdDataSelect;

  always_comb begin
    next_state              = state;
    next_displayOn          = displayOn;
    next_segReverse         = segReverse;
    next_reversePolarity    = reversePolarity;
    next_allPointsOn        = allPointsOn;
    next_biasSelect         = biasSelect;
    next_comScanReverse     = comScanReverse;
    next_rmwActive          = rmwActive;
    next_testMode           = testMode;
    next_boosterEn          = boosterEn;
    next_regulatorEn        = regulatorEn;
    next_followerEn         = followerEn;
    next_regulatorGainRatio = regulatorGainRatio;
    next_volumeLevel        = volumeLevel;
    next_indicatorOn        = indicatorOn;
    next_indicatorMode      = indicatorMode;
    next_pageAddr           = pageAddr;
    next_startLine          = startLine;
    next_ramWrEn            = 1'b0;
    next_ramWrData          = ramWrData;
    next_ramPage            = ramPage;
    next_ramColumn          = ramColumn;
    colBus.setHigh          = 1'b0;
    colBus.setLow           = 1'b0;
    colBus.nibble           = hostData[`FLD_NIBBLE_MSB:0];
    colBus.advance          = 1'b0;
    colBus.save             = 1'b0;
    colBus.restore          = 1'b0;
    colBus.softReset        = 1'b0;

    // Data bytes land at the address current before the advance
    if (dataWrite) begin
      next_ramWrEn   = 1'b1;                                                         // RULE_01
      next_ramWrData = hostData;
      next_ramPage   = pageAddr;
      next_ramColumn = colBus.colAddr;
      colBus.advance = 1'b1;                                                         // RULE_08
    end else if (dataRead) begin
      colBus.advance = ~rmwActive;                                                   // RULE_08
    end

    if (cmdWrite) begin
      unique case (state)
        lcd_cmd_pkg::ST_VOLUME: begin
          next_volumeLevel = hostData[`FLD_VOLUME_MSB:0];                             // RULE_18
          next_state       = lcd_cmd_pkg::ST_COMMAND;
        end
        lcd_cmd_pkg::ST_INDICATOR: begin
          next_indicatorMode = hostData[`FLD_IND_MSB:0];
          next_state         = lcd_cmd_pkg::ST_COMMAND;
        end
        lcd_cmd_pkg::ST_COMMAND: begin
          casez (hostData)
            `OP_DISP_ONOFF:  next_displayOn       = hostData[`FLD_SETTING];
            `OP_SEG_DIR:     next_segReverse      = hostData[`FLD_SETTING];
            `OP_REVERSE:     next_reversePolarity = hostData[`FLD_SETTING];              // RULE_04
            `OP_ALL_ON:      next_allPointsOn     = hostData[`FLD_SETTING];              // RULE_05
            `OP_BIAS:        next_biasSelect      = hostData[`FLD_SETTING];              // RULE_07
            `OP_START_LINE:  next_startLine       = hostData[`FLD_LINE_MSB:0];
            `OP_PAGE_SET:    next_pageAddr        = hostData[`FLD_NIBBLE_MSB:0];
            // A column set during read/modify/write is the host's fault; it is obeyed
            `OP_COL_HIGH:    colBus.setHigh       = 1'b1;                                // RULE_10
            `OP_COL_LOW:     colBus.setLow        = 1'b1;
            `OP_COM_SCAN:    next_comScanReverse  = hostData[`FLD_COM_SCAN];             // RULE_14
            `OP_POWER_CTRL: begin
              next_boosterEn   = hostData[`FLD_BOOSTER];                                 // RULE_15
              next_regulatorEn = hostData[`FLD_REGULATOR];
              next_followerEn  = hostData[`FLD_FOLLOWER];
            end
            `OP_GAIN_RATIO:  next_regulatorGainRatio = hostData[`FLD_RATIO_MSB:0];       // RULE_16
            `OP_VOLUME_MODE: next_state = lcd_cmd_pkg::ST_VOLUME;                        // RULE_17
            `OP_INDICATOR: begin
              next_indicatorOn = hostData[`FLD_SETTING];
              if (hostData[`FLD_SETTING]) begin
                next_state = lcd_cmd_pkg::ST_INDICATOR;
              end
            end
            `OP_RMW_ENTER: begin
              // Re-entry while active keeps the first saved column
              if (!rmwActive) begin
                colBus.save = 1'b1;                                                      // RULE_08
              end
              next_rmwActive = 1'b1;
            end
            `OP_RMW_END: begin
              if (rmwActive) begin
                colBus.restore = 1'b1;                                                   // RULE_09
              end
              next_rmwActive = 1'b0;
            end
            `OP_SOFT_RESET: begin
              // Applied on the strobe of the complete byte; RAM port untouched
              next_startLine          = `LINE_RST;                                       // RULE_11
              next_pageAddr           = `PAGE_RST;
              colBus.softReset        = 1'b1;
              next_comScanReverse     = 1'b0;
              next_regulatorGainRatio = `RATIO_RST;
              next_volumeLevel        = `VOLUME_RST;
              next_indicatorOn        = 1'b0;
              next_indicatorMode      = `IND_RST;
              next_rmwActive          = 1'b0;
              next_testMode           = 1'b0;                                            // RULE_12
            end
            `OP_NOP:         next_testMode = 1'b0;
            `OP_TEST:        next_testMode = 1'b1;
            default: begin
            end
          endcase
        end
        default: next_state = lcd_cmd_pkg::ST_COMMAND;
      endcase
    end

    // Power save follows from all-on with the display off, in either order
    next_powerSave = next_allPointsOn & ~next_displayOn;                                 // RULE_06
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state              <= lcd_cmd_pkg::ST_COMMAND;
      displayOn          <= 1'b0;
      segReverse         <= 1'b0;
      reversePolarity    <= 1'b0;
      allPointsOn        <= 1'b0;
      powerSave          <= 1'b0;
      biasSelect         <= 1'b0;
      comScanReverse     <= 1'b0;
      rmwActive          <= 1'b0;
      testMode           <= 1'b0;
      boosterEn          <= 1'b0;
      regulatorEn        <= 1'b0;
      followerEn         <= 1'b0;
      regulatorGainRatio <= `RATIO_RST;
      volumeLevel        <= `VOLUME_RST;
      indicatorOn        <= 1'b0;
      indicatorMode      <= `IND_RST;
      pageAddr           <= `PAGE_RST;
      startLine          <= `LINE_RST;
      ramWrEn            <= 1'b0;
      ramWrData          <= 8'h00;
      ramPage            <= `PAGE_RST;
      ramColumn          <= `COL_RST;
    end else begin
      state              <= next_state;
      displayOn          <= next_displayOn;
      segReverse         <= next_segReverse;
      reversePolarity    <= next_reversePolarity;
      allPointsOn        <= next_allPointsOn;
      powerSave          <= next_powerSave;
      biasSelect         <= next_biasSelect;
      comScanReverse     <= next_comScanReverse;
      rmwActive          <= next_rmwActive;
      testMode           <= next_testMode;
      boosterEn          <= next_boosterEn;
      regulatorEn        <= next_regulatorEn;
      followerEn         <= next_followerEn;
      regulatorGainRatio <= next_regulatorGainRatio;
      volumeLevel        <= next_volumeLevel;
      indicatorOn        <= next_indicatorOn;
      indicatorMode      <= next_indicatorMode;
      pageAddr           <= next_pageAddr;
      startLine          <= next_startLine;
      ramWrEn            <= next_ramWrEn;
      ramWrData          <= next_ramWrData;
      ramPage            <= next_ramPage;
      ramColumn          <= next_ramColumn;
    end
  end

  assign columnAddr = colBus.colAddr;
  assign volumeMode = (state == lcd_cmd_pkg::ST_VOLUME);

endmodule : lcd_command_decoder

/* lcd_command_decoder_assertions.sv */
// Port-level assertions for the LCD command decoder
`timescale 1ns/1ps
module lcd_command_decoder_assertions (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Host port
  input wire logic       hostWrStrobe,
  input wire logic       hostRdStrobe,
  input wire logic       cmdDataSelect,
  input wire logic [7:0] hostData,
  // Decoded state
  input wire logic [7:0] columnAddr,
  input wire logic       reversePolarity,
  input wire logic       allPointsOn,
  input wire logic       displayOn,
  input wire logic       powerSave,
  input wire logic       comScanReverse,
  input wire logic       rmwActive,
  input wire logic       volumeMode,
  input wire logic [5:0] volumeLevel,
  input wire logic [2:0] regulatorGainRatio,
  input wire logic       boosterEn,
  input wire logic       regulatorEn,
  input wire logic       followerEn
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // The byte after indicator-on opcode AD is a value, so it must not count as a command here
  logic indWait;
  logic cmd;
  assign cmd = hostWrStrobe && !cmdDataSelect && !volumeMode && !indWait;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      indWait <= 1'b0;
    end else if (hostWrStrobe && !cmdDataSelect) begin
      indWait <= cmd && hostData == 8'had;
    end
  end

  a_polarity_load: assert property (cmd && hostData[7:1] == 7'h53
    |=> reversePolarity == $past(hostData[0])) else $error("polarity not loaded");
  a_all_on_load: assert property (cmd && hostData[7:1] == 7'h52
    |=> allPointsOn == $past(hostData[0])) else $error("all-on not loaded");
  a_power_save: assert property (powerSave == (allPointsOn && !displayOn))
    else $error("power save mismatch");
  a_scan_dir: assert property (cmd && hostData[7:4] == 4'hc
    |=> comScanReverse == $past(hostData[3])) else $error("scan direction wrong");
  a_power_bits: assert property (cmd && hostData[7:3] == 5'h05
    |=> {boosterEn, regulatorEn, followerEn} == $past(hostData[2:0])) else $error("power enables wrong");
  a_gain_ratio: assert property (cmd && hostData[7:3] == 5'h04
    |=> regulatorGainRatio == $past(hostData[2:0])) else $error("gain ratio wrong");
  a_volume_wait: assert property (cmd && hostData == 8'h81 |=> volumeMode)
    else $error("volume wait missing");
  a_volume_load: assert property (hostWrStrobe && !cmdDataSelect && volumeMode
    |=> !volumeMode && volumeLevel == $past(hostData[5:0])) else $error("volume not loaded");
  a_column_top: assert property (hostWrStrobe && cmdDataSelect && columnAddr == 8'h83
    |=> columnAddr == 8'h83) else $error("column passed its top");
  a_rmw_read: assert property (hostRdStrobe && cmdDataSelect && rmwActive
    |=> $stable(columnAddr)) else $error("read moved column in rmw");
  a_soft_reset: assert property (cmd && hostData == 8'he2 |=> columnAddr == 8'h00
    && volumeLevel == 6'h20 && !rmwActive && !comScanReverse && regulatorGainRatio == 3'h0)
    else $error("soft reset incomplete");
endmodule : lcd_command_decoder_assertions

bind lcd_command_decoder lcd_command_decoder_assertions i_lcd_command_decoder_assertions (.*);

/* lcd_host_model.sv */
// Host processor model driving the command/data port
`timescale 1ns/1ps
module lcd_host_model (
  // Clock
  input wire logic   clk,
  // Host port
  output logic       hostWrStrobe,
  output logic       hostRdStrobe,
  output logic       cmdDataSelect,
  output logic [7:0] hostData
);
  initial begin
    hostWrStrobe  = 1'b0;
    hostRdStrobe  = 1'b0;
    cmdDataSelect = 1'b0;
    hostData      = 8'h00;
  end

  // Idle select and data lines show the inverse of the last value so a stale byte never looks valid
  task automatic access(input logic sel, input logic rd, input logic [7:0] b);
    @(posedge clk);
    hostWrStrobe  <= !rd;
    hostRdStrobe  <= rd;
    cmdDataSelect <= sel;
    hostData      <= b;
    @(posedge clk);
    hostWrStrobe  <= 1'b0;
    hostRdStrobe  <= 1'b0;
    cmdDataSelect <= !sel;
    hostData      <= ~b;
  endtask : access

  // Value byte goes out straight after its mode byte
  task automatic volume(input logic [7:0] v);
    access(1'b0, 1'b0, 8'h81);
    access(1'b0, 1'b0, v);
  endtask : volume
endmodule : lcd_host_model

/* lcd_command_decoder_test.sv */
// Self-checking bench for the LCD command decoder
`timescale 1ns/1ps
module lcd_command_decoder_test;
  logic       clk;
  logic       sys_rst;
  logic       hostWrStrobe, hostRdStrobe, cmdDataSelect;
  logic [7:0] hostData, ramWrData, ramColumn, columnAddr;
  logic [3:0] ramPage, pageAddr;
  logic [5:0] startLine, volumeLevel;
  logic [2:0] regulatorGainRatio;
  logic [1:0] indicatorMode;
  logic       ramWrEn, displayOn, segReverse, reversePolarity, allPointsOn, powerSave, biasSelect;
  logic       comScanReverse, rmwActive, testMode, volumeMode, boosterEn, regulatorEn, followerEn;
  logic       indicatorOn;
  int         n_mismatch  = 0;
  int         checks_done = 0;
  int         cycles      = 0;

  lcd_command_decoder i_lcd_command_decoder (.*);
  lcd_host_model i_lcd_host_model (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The #1 lets the taking edge's updates land before anything is sampled
  task automatic cmd(input logic [7:0] b);
    i_lcd_host_model.access(1'b0, 1'b0, b);
    #1;
  endtask : cmd

  task automatic dat(input logic rd, input logic [7:0] b);
    i_lcd_host_model.access(1'b1, rd, b);
    #1;
  endtask : dat

  task automatic end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    sys_rst = 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk(8'(volumeLevel), 8'h20);
    // Set then clear; only the set pass's scan opcode CB has free bits set, D1 and D0
    for (int i = 1; i >= 0; i--) begin
      cmd(8'ha6 + 8'(i));
      chk(8'(reversePolarity), 8'(i));
      cmd(8'ha4 + 8'(i));
      chk(8'(allPointsOn), 8'(i));
      cmd(8'ha2 + 8'(i));
      chk(8'(biasSelect), 8'(i));
      cmd(8'hc0 + 8'(i * 11));
      chk(8'(comScanReverse), 8'(i));
    end
    for (int i = 0; i < 8; i++) begin
      cmd(8'h28 + 8'(i));
      chk(8'({boosterEn, regulatorEn, followerEn}), 8'(i));
      cmd(8'h27 - 8'(i));
      chk(8'(regulatorGainRatio), 8'(7 - i));
    end
    cmd(8'h35);
    chk(8'({boosterEn, regulatorEn, followerEn}), 8'h07);
    cmd(8'hae);
    cmd(8'ha5);
    chk(8'(powerSave), 8'h01);
    cmd(8'haf);
    chk(8'(powerSave), 8'h00);
    chk(8'(displayOn), 8'h01);
    cmd(8'ha1);
    chk(8'(segReverse), 8'h01);
    cmd(8'ha4);
    // A reset opcode inside the volume pair is only a value
    cmd(8'h81);
    chk(8'(volumeMode), 8'h01);
    cmd(8'he2);
    chk(8'(volumeLevel), 8'h22);
    chk(8'(volumeMode), 8'h00);
    cmd(8'h18);
    cmd(8'h02);
    chk(columnAddr, 8'h82);
    for (int i = 0; i < 3; i++) begin
      dat(1'b0, 8'h5a + 8'(i));
      chk(8'(ramWrEn), 8'h01);
      chk(ramWrData, 8'h5a + 8'(i));
      chk(ramColumn, i == 0 ? 8'h82 : 8'h83);
      chk(columnAddr, 8'h83);
    end
    cmd(8'h11);
    cmd(8'h00);
    cmd(8'he0);
    chk(8'(rmwActive), 8'h01);
    dat(1'b1, 8'h00);
    chk(columnAddr, 8'h10);
    dat(1'b0, 8'h33);
    dat(1'b0, 8'h34);
    chk(columnAddr, 8'h12);
    cmd(8'ha7);
    cmd(8'hee);
    chk(columnAddr, 8'h10);
    chk(8'(rmwActive), 8'h00);
    cmd(8'h45);
    chk(8'(startLine), 8'h05);
    cmd(8'hb3);
    chk(8'(pageAddr), 8'h03);
    cmd(8'hc8);
    chk(8'(comScanReverse), 8'h01);
    cmd(8'h25);
    chk(8'(regulatorGainRatio), 8'h05);
    cmd(8'hf0);
    chk(8'(testMode), 8'h01);
    // Indicator pair: a reset opcode as its second byte is only a value
    cmd(8'had);
    chk(8'(indicatorOn), 8'h01);
    cmd(8'he2);
    chk(8'(indicatorMode), 8'h02);
    chk(8'(startLine), 8'h05);
    i_lcd_host_model.volume(8'h20);
    #1;
    chk(8'(volumeLevel), 8'h20);
    cmd(8'he0);
    i_lcd_host_model.volume(8'h05);
    #1;
    chk(8'(volumeLevel), 8'h05);
    cmd(8'he2);
    chk(8'(startLine), 8'h00);
    chk(8'(pageAddr), 8'h00);
    chk(columnAddr, 8'h00);
    chk(8'(comScanReverse), 8'h00);
    chk(8'(regulatorGainRatio), 8'h00);
    chk(8'(volumeLevel), 8'h20);
    chk(8'({rmwActive, testMode}), 8'h00);
    chk(8'({indicatorOn, indicatorMode}), 8'h00);
    chk(8'(reversePolarity), 8'h01);
    chk(8'(ramWrEn), 8'h00);
    end_of_test();
  end
endmodule : lcd_command_decoder_test
